//--- core/ucb_pkg.sv
// Package: register map, field layout and timing counts of the port control
package ucb_pkg;
  // Register indices (byte address = index * 4)
  localparam logic [2:0] IDX_CON0 = 3'h0;
  localparam logic [2:0] IDX_CON1 = 3'h1;
  localparam logic [2:0] IDX_CON2 = 3'h2;
  localparam logic [2:0] IDX_STAT = 3'h3;
  localparam logic [2:0] IDX_BRG  = 3'h4;
  localparam logic [2:0] IDX_TXB  = 3'h5;
  // Reset values
  localparam logic [7:0]  CON_RST = 8'h00;
  localparam logic [15:0] BRG_RST = 16'h0000;
  // Status bit positions
  localparam int ST_BRK  = 0;
  localparam int ST_IRQ  = 1;
  localparam int ST_IDLE = 2;
  localparam int ST_TXBE = 3;
  localparam int ST_TXBS = 4;
  localparam int ST_OVF  = 5;
  localparam int ST_RXBE = 6;
  // Mode encodings
  localparam logic [3:0] MD_ASYNC8 = 4'h0;
  localparam logic [3:0] MD_ASYNC7 = 4'h1;
  localparam logic [3:0] MD_ODD9   = 4'h2;
  localparam logic [3:0] MD_EVEN9  = 4'h3;
  localparam logic [3:0] MD_ADDR9  = 4'h4;
  localparam logic [3:0] MD_DALID  = 4'h8;
  localparam logic [3:0] MD_DALIG  = 4'h9;
  localparam logic [3:0] MD_DMX    = 4'hA;
  localparam logic [3:0] MD_LINS   = 4'hB;
  localparam logic [3:0] MD_LINM   = 4'hC;
  // Stop and flow encodings
  localparam logic [1:0] STP_ONE  = 2'h0;
  localparam logic [1:0] STP_HALF = 2'h1;
  localparam logic [1:0] STP_TWO2 = 2'h2;
  localparam logic [1:0] STP_TWO1 = 2'h3;
  localparam logic [1:0] FLO_OFF  = 2'h0;
  localparam logic [1:0] FLO_XON  = 2'h1;
  localparam logic [1:0] FLO_HW   = 2'h2;
  // Timing counts in bit periods, baud clocks and sync edges
  localparam logic [8:0] BRK_BITS_ASYNC = 9'd11;
  localparam logic [8:0] BRK_BITS_DMX   = 9'd23;
  localparam logic [3:0] TX_BRK_ZEROS   = 4'd13;
  localparam logic [4:0] BCLK_FAST      = 5'd4;
  localparam logic [4:0] BCLK_NORM      = 5'd16;
  localparam logic [2:0] ABD_EDGES      = 3'd5;
  // Control register layouts
  typedef struct packed {
    logic       baud_speed_select;
    logic       autobaud_enable;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic [3:0] mode;
  } ucb_con0_t;
  typedef struct packed {
    logic       on;
    logic [1:0] rsv1;
    logic       wake_enable;
    logic       break_irq_timing_select;
    logic       rsv0;
    logic       break_force_override;
    logic       send_break_request;
  } ucb_con1_t;
  typedef struct packed {
    logic       run_after_overflow;
    logic       rx_invert;
    logic [1:0] stop_bit_select;
    logic       checksum_mode_select;
    logic       tx_invert;
    logic [1:0] flow_control_select;
  } ucb_con2_t;
endpackage

//--- core/ucb_uart_ctrl.sv
// UART control registers, baud timing, break receive/send and wake logic
// Operation
// - Break after 11 bits, 23 in DMX
// - Break flag at minimum time or idle return
// - Sleep stops port; wake detect still runs
// - Four or sixteen baud clocks per bit
// - Autobaud waits sync, hardware clears enable
// - Autobaud enable ignored in DALI modes
// - Transmit enable forces pin drive while active
// - Transmit/receive enable clears never flush data buffers
// - Asynchronous mode field encodings
// - Protocol mode encodings, first port only
// - Port enable low holds port in reset
// - Wake waits falling edge, sets flag, clears
// - Break override forces TX non-idle
// - Send break precedes next written byte
// - Send break read-only in protocol modes
// - Overflow halts receive unless run enabled
// - Receive polarity inversion, idle low
// - Stop-bit field encodings
// - Only DMX/DALI check every stop bit
// - Checksum select meaning per mode
// - Transmit polarity inversion, idle low
// - Flow control field encodings
// - Receive idle status reports line activity
`timescale 1ns/1ps
`default_nettype none
module ucb_uart_ctrl #(
  parameter bit FIRST_PORT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial pins and system
  input  wire logic        rxPin,
  input  wire logic        sleepReq,
  input  wire logic        portDriveEn,
  input  wire logic        rxOverflow,
  output logic             txPin,
  output logic             txOe,
  // Status towards the rest of the port
  output logic             uartIrqFlag,
  output logic             rxFlush,
  output logic             stopCheckAll,
  output logic             chkInclId,
  output logic             chkEnable,
  output logic             flowXon,
  output logic             txDriveEn
);
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b0_0001,
    TX_BRK   = 5'b0_0010,
    TX_START = 5'b0_0100,
    TX_DATA  = 5'b0_1000,
    TX_STOP  = 5'b1_0000
  } ucb_txst_t;

  ucb_pkg::ucb_con0_t con0_q, con0_d;
  ucb_pkg::ucb_con1_t con1_q, con1_d;
  ucb_pkg::ucb_con2_t con2_q, con2_d;
  logic [15:0] brg_q, brg_d;
  logic        ack_q;
  logic [31:0] rdat_q, rdat_d;
  logic        brkFlag_q, brkFlag_d, irqFlag_q, irqFlag_d;
  logic        ovf_q, ovf_d, rxFlush_q, rxFlush_d;
  logic        rxS1_q, rxS2_q, rxLast_q;
  logic [15:0] brgCnt_q, brgCnt_d;
  logic [8:0]  spCnt_q, spCnt_d;
  logic        brkSeen_q, brkSeen_d, idle_q, idle_d;
  logic [2:0]  abdEdg_q, abdEdg_d;
  ucb_txst_t   txSt_q, txSt_d;
  logic [7:0]  txHold_q, txHold_d, txSh_q, txSh_d;
  logic        txPend_q, txPend_d, txLvl_q, txLvl_d;
  logic        txBrk_q, txBrk_d;
  logic [4:0]  txSub_q, txSub_d;
  logic [3:0]  txBit_q, txBit_d;
  logic        wbReq, wbWr, lane0, run, portRst;
  logic        rxLine, fallEdge, spaceNow, rxHalt, protoMode;
  logic        baudTick, abdOn, dmxMode, daliMode, linMode;
  logic [4:0]  perBit, stopLim;
  logic [8:0]  brkLim;
  logic        txbWr, txFlush, bitEnd, sendbClr;

  // Port runs only when enabled and awake
  assign portRst  = ~con1_q.on;
  assign run      = con1_q.on & ~sleepReq;
  assign wbReq    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wbWr     = wbReq & wb_we_i;
  assign lane0    = wb_sel_i[0];
  assign txbWr    = wbWr & lane0 & (wb_adr_i == ucb_pkg::IDX_TXB);
  assign txFlush  = wbWr & lane0 & (wb_adr_i == ucb_pkg::IDX_STAT) &
                    wb_dat_i[ucb_pkg::ST_TXBE];

  // Mode decode; protocol codes only exist on the first port
  assign protoMode = FIRST_PORT & con0_q.mode[3];
  assign daliMode  = protoMode & (con0_q.mode[3:1] ==
                     ucb_pkg::MD_DALID[3:1]);
  assign dmxMode   = protoMode & (con0_q.mode == ucb_pkg::MD_DMX);
  assign linMode   = protoMode & ((con0_q.mode == ucb_pkg::MD_LINS) |
                     (con0_q.mode == ucb_pkg::MD_LINM));
  assign abdOn     = con0_q.autobaud_enable & ~daliMode;
  assign perBit    = con0_q.baud_speed_select ? ucb_pkg::BCLK_FAST
                                 : ucb_pkg::BCLK_NORM;
  assign brkLim    = dmxMode ? ucb_pkg::BRK_BITS_DMX * {4'h0, perBit}
                   : ucb_pkg::BRK_BITS_ASYNC * {4'h0, perBit};

  // Line-format decodes handed to the shifters
  assign stopCheckAll = (dmxMode | daliMode) &
                        (con2_q.stop_bit_select == ucb_pkg::STP_TWO2);
  assign chkInclId = linMode & con2_q.checksum_mode_select;
  assign chkEnable = con2_q.checksum_mode_select;
  assign flowXon   = con2_q.flow_control_select == ucb_pkg::FLO_XON;
  assign txDriveEn = (con2_q.flow_control_select == ucb_pkg::FLO_HW) &
                     (txSt_q != TX_IDLE);
  assign uartIrqFlag = irqFlag_q;
  assign rxFlush     = rxFlush_q;

  // Register file next state; hardware sets beat software clears
  always_comb begin
    con0_d    = con0_q;
    con1_d    = con1_q;
    con2_d    = con2_q;
    brg_d     = brg_q;
    brkFlag_d = brkFlag_q;
    irqFlag_d = irqFlag_q;
    ovf_d     = ovf_q;
    rxFlush_d = 1'b0;
    if (wbWr && lane0) begin
      case (wb_adr_i)
        ucb_pkg::IDX_CON0: con0_d = wb_dat_i[7:0];
        ucb_pkg::IDX_CON1: begin
          con1_d = wb_dat_i[7:0];
          con1_d.rsv1 = 2'b00;
          con1_d.rsv0 = 1'b0;
          if (protoMode) begin
            con1_d.send_break_request = con1_q.send_break_request;
          end
        end
        ucb_pkg::IDX_CON2: con2_d = wb_dat_i[7:0];
        ucb_pkg::IDX_STAT: begin
          if (wb_dat_i[ucb_pkg::ST_BRK]) brkFlag_d = 1'b0;
          if (wb_dat_i[ucb_pkg::ST_IRQ]) irqFlag_d = 1'b0;
          if (wb_dat_i[ucb_pkg::ST_OVF]) ovf_d = 1'b0;
          rxFlush_d = wb_dat_i[ucb_pkg::ST_RXBE];
        end
        default: ;
      endcase
    end
    if (wbWr && (wb_adr_i == ucb_pkg::IDX_BRG)) begin
      if (lane0) brg_d[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) brg_d[15:8] = wb_dat_i[15:8];
    end
    // Auto-baud ends on the fifth falling edge of the sync byte
    if (run && abdOn && fallEdge &&
        abdEdg_q == ucb_pkg::ABD_EDGES - 3'd1) begin
      con0_d.autobaud_enable = 1'b0;
    end
    // Wake: first edge out of idle raises the flag, ends the wait
    if (con1_q.wake_enable && fallEdge) begin
      irqFlag_d  = 1'b1;
      con1_d.wake_enable = 1'b0;
    end
    if (sendbClr) con1_d.send_break_request = 1'b0;
    if (run && rxOverflow) ovf_d = 1'b1;
    if (run && con0_q.receive_enable_bit && !rxHalt && !con1_q.wake_enable) begin
      if (spaceNow && spCnt_q == brkLim && baudTick &&
          con1_q.break_irq_timing_select) begin
        brkFlag_d = 1'b1;
      end
      if (!spaceNow && brkSeen_q && !con1_q.break_irq_timing_select) begin
        brkFlag_d = 1'b1;
      end
    end
    if (portRst) begin
      brkFlag_d = 1'b0;
      ovf_d     = 1'b0;
    end
  end

  // Read mux; unmapped words read zero but still acknowledge
  always_comb begin
    rdat_d = 32'h0000_0000;
    case (wb_adr_i)
      ucb_pkg::IDX_CON0: rdat_d[7:0] = con0_q;
      ucb_pkg::IDX_CON1: rdat_d[7:0] = con1_q;
      ucb_pkg::IDX_CON2: rdat_d[7:0] = con2_q;
      ucb_pkg::IDX_STAT: begin
        rdat_d[ucb_pkg::ST_BRK]  = brkFlag_q;
        rdat_d[ucb_pkg::ST_IRQ]  = irqFlag_q;
        rdat_d[ucb_pkg::ST_IDLE] = idle_q;
        rdat_d[ucb_pkg::ST_TXBE] = ~txPend_q;
        rdat_d[ucb_pkg::ST_TXBS] = txSt_q != TX_IDLE;
        rdat_d[ucb_pkg::ST_OVF]  = ovf_q;
      end
      ucb_pkg::IDX_BRG: rdat_d[15:0] = brg_q;
      default: ;
    endcase
  end

  // Registers and the one-cycle bus acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      con0_q    <= ucb_pkg::CON_RST;
      con1_q    <= ucb_pkg::CON_RST;
      con2_q    <= ucb_pkg::CON_RST;
      brg_q     <= ucb_pkg::BRG_RST;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0000_0000;
      brkFlag_q <= 1'b0;
      irqFlag_q <= 1'b0;
      ovf_q     <= 1'b0;
      rxFlush_q <= 1'b0;
    end else begin
      con0_q    <= con0_d;
      con1_q    <= con1_d;
      con2_q    <= con2_d;
      brg_q     <= brg_d;
      ack_q     <= wbReq;
      rdat_q    <= rdat_d;
      brkFlag_q <= brkFlag_d;
      irqFlag_q <= irqFlag_d;
      ovf_q     <= ovf_d;
      rxFlush_q <= rxFlush_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxS1_q   <= 1'b1;
      rxS2_q   <= 1'b1;
      rxLast_q <= 1'b1;
    end else begin
      rxS1_q   <= rxPin;
      rxS2_q   <= rxS1_q;
      rxLast_q <= rxLine;
    end
  end
  // Polarity applied before any space/idle decision
  assign rxLine   = rxS2_q ^ con2_q.rx_invert;
  assign spaceNow = ~rxLine;
  assign fallEdge = rxLast_q & ~rxLine;
  assign rxHalt   = ovf_q & ~con2_q.run_after_overflow;
  assign baudTick = run && (brgCnt_q == 16'h0000);

  // Baud counter, break timer, idle status and sync edge count
  always_comb begin
    brgCnt_d  = brgCnt_q;
    spCnt_d   = spCnt_q;
    brkSeen_d = brkSeen_q;
    abdEdg_d  = abdEdg_q;
    idle_d    = idle_q;
    if (run) begin
      brgCnt_d = baudTick ? brg_q : brgCnt_q - 16'h0001;
      if (!spaceNow || !con0_q.receive_enable_bit || rxHalt || con1_q.wake_enable) begin
        spCnt_d   = 9'h000;
        brkSeen_d = 1'b0;
      end else if (baudTick && spCnt_q != brkLim) begin
        spCnt_d = spCnt_q + 9'h001;
      end else if (baudTick) begin
        brkSeen_d = 1'b1;
      end
      if (!abdOn) begin
        abdEdg_d = 3'h0;
      end else if (fallEdge) begin
        abdEdg_d = abdEdg_q + 3'h1;
      end
      idle_d = rxLine && (abdEdg_q == 3'h0 || !abdOn) &&
               !brkSeen_q;
    end
    if (portRst) begin
      brgCnt_d  = 16'h0000;
      spCnt_d   = 9'h000;
      brkSeen_d = 1'b0;
      abdEdg_d  = 3'h0;
      idle_d    = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brgCnt_q  <= 16'h0000;
      spCnt_q   <= 9'h000;
      brkSeen_q <= 1'b0;
      abdEdg_q  <= 3'h0;
      idle_q    <= 1'b1;
    end else begin
      brgCnt_q  <= brgCnt_d;
      spCnt_q   <= spCnt_d;
      brkSeen_q <= brkSeen_d;
      abdEdg_q  <= abdEdg_d;
      idle_q    <= idle_d;
    end
  end

  // Transmitter: half-period limit only for the 1.5 stop case
  assign stopLim = (txSt_q == TX_STOP && txBit_q == 4'h1 &&
                   con2_q.stop_bit_select == ucb_pkg::STP_HALF) ?
                   perBit >> 1 : perBit;
  assign bitEnd  = baudTick && (txSub_q == stopLim - 5'd1);
  assign sendbClr = bitEnd && txBrk_q && txSt_q == TX_STOP;

  always_comb begin
    txSt_d   = txSt_q;
    txHold_d = txHold_q;
    txPend_d = txPend_q;
    txSh_d   = txSh_q;
    txLvl_d  = txLvl_q;
    txBrk_d  = txBrk_q;
    txSub_d  = txSub_q;
    txBit_d  = txBit_q;
    // Holding byte survives transmit/receive enable changes; only a flush or port reset drops it
    if (txbWr) begin
      txHold_d = wb_dat_i[7:0];
      txPend_d = 1'b1;
    end
    if (run) begin
      if (txSt_q != TX_IDLE && baudTick) begin
        txSub_d = bitEnd ? 5'h00 : txSub_q + 5'h01;
      end
      case (txSt_q)
        TX_IDLE: begin
          txLvl_d = 1'b1;
          if (txPend_q && con0_q.transmit_enable_bit) begin
            txSh_d   = txHold_q;
            txPend_d = txbWr;
            txSub_d  = 5'h00;
            txBit_d  = 4'h0;
            txLvl_d  = 1'b0;
            txBrk_d  = con1_q.send_break_request;
            txSt_d   = con1_q.send_break_request ? TX_BRK : TX_START;
          end
        end
        TX_BRK: if (bitEnd) begin
          txBit_d = txBit_q + 4'h1;
          if (txBit_q == ucb_pkg::TX_BRK_ZEROS - 4'h1) begin
            txLvl_d = 1'b1;
            txBit_d = 4'h0;
            txSt_d  = TX_STOP;
          end
        end
        TX_START: if (bitEnd) begin
          txLvl_d = txSh_q[0];
          txBit_d = 4'h0;
          txSt_d  = TX_DATA;
        end
        TX_DATA: if (bitEnd) begin
          txSh_d  = {1'b0, txSh_q[7:1]};
          txLvl_d = txSh_q[1];
          txBit_d = txBit_q + 4'h1;
          if (txBit_q == ((con0_q.mode == ucb_pkg::MD_ASYNC7) ?
                          4'h6 : 4'h7)) begin
            txLvl_d = 1'b1;
            txBit_d = 4'h0;
            txSt_d  = TX_STOP;
          end
        end
        TX_STOP: if (bitEnd) begin
          txBit_d = txBit_q + 4'h1;
          if (txBrk_q) begin
            txBrk_d = 1'b0;
            txLvl_d = 1'b0;
            txBit_d = 4'h0;
            txSt_d  = TX_START;
          end else if (txBit_q == 4'h1 ||
                       con2_q.stop_bit_select == ucb_pkg::STP_ONE) begin
            txSt_d = TX_IDLE;
          end
        end
        default: txSt_d = TX_IDLE;
      endcase
    end
    if (txFlush || portRst) begin
      txSt_d   = TX_IDLE;
      txPend_d = 1'b0;
      txLvl_d  = 1'b1;
      txBrk_d  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txSt_q   <= TX_IDLE;
      txHold_q <= 8'h00;
      txPend_q <= 1'b0;
      txSh_q   <= 8'h00;
      txLvl_q  <= 1'b1;
      txBrk_q  <= 1'b0;
      txSub_q  <= 5'h00;
      txBit_q  <= 4'h0;
    end else begin
      txSt_q   <= txSt_d;
      txHold_q <= txHold_d;
      txPend_q <= txPend_d;
      txSh_q   <= txSh_d;
      txLvl_q  <= txLvl_d;
      txBrk_q  <= txBrk_d;
      txSub_q  <= txSub_d;
      txBit_q  <= txBit_d;
    end
  end

  // Override beats the shifter; polarity applied last
  assign txPin = (txLvl_q & ~con1_q.break_force_override) ^ con2_q.tx_invert;
  assign txOe  = (con0_q.transmit_enable_bit && txSt_q != TX_IDLE) ? 1'b1
               : portDriveEn;

  // Checks beside the logic
  property p_brkImm;
    @(posedge clk) disable iff (rst)
    (run && con0_q.receive_enable_bit && !rxHalt && !con1_q.wake_enable && spaceNow &&
     spCnt_q == brkLim && baudTick && con1_q.break_irq_timing_select)
    |=> brkFlag_q;
  endproperty
  a_brkImm: assert property (p_brkImm) else $error("break flag late");
  property p_brkEnd;
    @(posedge clk) disable iff (rst)
    (brkFlag_q == 1'b0 && $rose(brkFlag_q) == 1'b0 && !con1_q.break_irq_timing_select
     && spaceNow) |=> !brkFlag_q || $past(wbWr);
  endproperty
  a_brkEnd: assert property (p_brkEnd) else $error("break flag early");
  property p_brkLen;
    @(posedge clk) disable iff (rst)
    $rose(brkSeen_q) |-> spCnt_q == brkLim;
  endproperty
  a_brkLen: assert property (p_brkLen) else $error("break length");
  property p_wake;
    @(posedge clk) disable iff (rst)
    (con1_q.wake_enable && fallEdge) |=> (irqFlag_q && !con1_q.wake_enable);
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");
  property p_off;
    @(posedge clk) disable iff (rst)
    portRst |=> (txSt_q == TX_IDLE && !brkFlag_q);
  endproperty
  a_off: assert property (p_off) else $error("port not reset");
  property p_sleep;
    @(posedge clk) disable iff (rst)
    sleepReq |=> $stable(txSt_q) || portRst || $past(txFlush);
  endproperty
  a_sleep: assert property (p_sleep) else $error("runs in sleep");
  property p_oe;
    @(posedge clk) disable iff (rst)
    (con0_q.transmit_enable_bit && txSt_q != TX_IDLE) |-> txOe;
  endproperty
  a_oe: assert property (p_oe) else $error("tx not driven");
  property p_ovr;
    @(posedge clk) disable iff (rst)
    con1_q.break_force_override |-> txPin == con2_q.tx_invert;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override lost");
  property p_sendbRo;
    @(posedge clk) disable iff (rst)
    (protoMode && !sendbClr) |=> con1_q.send_break_request == $past(con1_q.send_break_request);
  endproperty
  a_sendbRo: assert property (p_sendbRo) else $error("send_break_request wrote");
  property p_abdDali;
    @(posedge clk) disable iff (rst)
    daliMode |=> abdEdg_q == 3'h0 || portRst;
  endproperty
  a_abdDali: assert property (p_abdDali) else $error("abd in dali");
  c_brk: cover property (@(posedge clk) $rose(brkFlag_q));
  c_wake: cover property (@(posedge clk) $fell(con1_q.wake_enable));
  c_sbrk: cover property (@(posedge clk) sendbClr);
endmodule
`default_nettype wire

//--- verif/ucb_remote_node.sv
// Remote serial node: drives the receive line, watches the transmit line
`timescale 1ns/1ps
`default_nettype none
module ucb_remote_node (
  // Clock
  input  wire logic clk,
  // Serial lines
  output logic      rxLine,
  input  wire logic txLine
);
  logic spc = 1'b0;
  logic inv = 1'b0;
  int   run = 0;
  int   maxRun = 0;
  // Space is the opposite of idle, so polarity follows the port setting
  assign rxLine = spc ^ ~inv;
  task automatic setSpace(input logic s);
    @(posedge clk);
    spc <= s;
  endtask
  task automatic setInv(input logic i);
    @(posedge clk);
    inv <= i;
  endtask
  // Longest low run on the transmit line, used to time a sent break
  always @(posedge clk) begin
    run <= txLine ? 0 : run + 1;
    if (run + 1 > maxRun && !txLine) maxRun <= run + 1;
  end
endmodule
`default_nettype wire

//--- verif/ucb_uart_ctrl_tb.sv
// Self-checking bench for the port control and break logic
`timescale 1ns/1ps
`default_nettype none
module ucb_uart_ctrl_tb;
  logic clk = 1'b0, rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [2:0] wbAdr = 3'h0;
  logic [31:0] wbDatW = 32'h0000_0000, wbDatR, q;
  logic wbAck, rxPin, txPin, txOe, uartIrqFlag, rxFlush;
  logic sleepReq = 1'b0, portDriveEn = 1'b0, rxOverflow = 1'b0;
  logic [3:0] wbSel = 4'hF;
  logic stopCheckAll, chkInclId, chkEnable, flowXon, txDriveEn;
  int numErrors = 0, cmpCount = 0, flushCnt = 0;
  logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                             4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  ucb_uart_ctrl ucb_uart_ctrl_inst (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rxPin(rxPin),
    .sleepReq(sleepReq), .portDriveEn(portDriveEn), .rxOverflow(rxOverflow),
    .txPin(txPin), .txOe(txOe), .uartIrqFlag(uartIrqFlag), .rxFlush(rxFlush),
    .stopCheckAll(stopCheckAll), .chkInclId(chkInclId),
    .chkEnable(chkEnable), .flowXon(flowXon), .txDriveEn(txDriveEn));
  ucb_remote_node ucb_remote_node_inst (.clk(clk), .rxLine(rxPin),
    .txLine(txPin));
  // Free-running system clock
  always #10 clk = ~clk;
  // Count flush pulses so that enable changes can be seen not to flush
  always @(posedge clk) if (rxFlush === 1'b1) flushCnt++;
  task automatic wrapUp;
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // One classic bus cycle; request held until ack is sampled
  task automatic xfer(input logic [2:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "no bus ack");
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic tReset;
    for (int i = 0; i < 3; i++) begin
      xfer(i[2:0], 1'b0, 32'h0, q);
      chk(q, 32'h0000_0000, "control reset value");
    end
    wr(3'h7, 32'h0000_00FF);
    xfer(3'h7, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0000, "unmapped read");
    // Baud reload: only the selected lane lands, then back to zero
    wbSel <= 4'h1;
    wr(3'h4, 32'h0000_1234);
    wbSel <= 4'hF;
    xfer(3'h4, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0034, "baud low lane only");
    wr(3'h4, 32'h0000_0000);
  endtask
  // Sync edges: the fifth ends auto-baud, DALI modes ignore the enable
  task automatic tAbd(input logic [7:0] c0, input logic [7:0] fin);
    wr(3'h0, {24'h0, c0});
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        xfer(3'h0, 1'b0, 32'h0, q);
        chk(q, {24'h0, c0}, "enable held before fifth edge");
      end
      ucb_remote_node_inst.setSpace(1'b1);
      repeat (3) @(posedge clk);
      ucb_remote_node_inst.setSpace(1'b0);
      repeat (3) @(posedge clk);
    end
    xfer(3'h0, 1'b0, 32'h0, q);
    chk(q, {24'h0, fin}, "auto-baud enable");
  endtask
  // Every mode code, with DMX/DALI stop checking and LIN checksum id
  task automatic tModes;
    wr(3'h2, 32'h0000_0029);
    chk(flowXon, 1'b1, "xon select");
    chk(chkEnable, 1'b1, "checksum select");
    for (int i = 0; i < 10; i++) begin
      wr(3'h0, {28'h0, modes[i]});
      xfer(3'h0, 1'b0, 32'h0, q);
      chk(q, {28'h0, modes[i]}, "mode readback");
      chk(stopCheckAll, modes[i] inside {8, 9, 10}, "stop check");
      chk(chkInclId, modes[i] inside {11, 12}, "lin id");
    end
    wr(3'h0, 32'h0000_000A);
    wr(3'h2, 32'h0000_0032);
    chk(stopCheckAll, 1'b0, "stop 11 check");
    chk(flowXon, 1'b0, "hw flow not xon");
    wr(3'h2, 32'h0000_0000);
  endtask
  task automatic tTxLine;
    wr(3'h1, 32'h0000_0080);
    wr(3'h2, 32'h0000_0004);
    chk(txPin, 1'b0, "inverted idle");
    wr(3'h2, 32'h0000_0000);
    chk(txPin, 1'b1, "plain idle");
    wr(3'h1, 32'h0000_0082);
    chk(txPin, 1'b0, "forced break");
    wr(3'h1, 32'h0000_0080);
    chk(txPin, 1'b1, "override off");
  endtask
  // Hold space for len cycles, look at the flag early and after return
  task automatic brk(input logic [7:0] c0, input logic [7:0] c1,
                     input int len, input logic det);
    wr(3'h0, {24'h0, c0});
    wr(3'h1, {24'h0, c1});
    wr(3'h3, 32'h0000_0001);
    ucb_remote_node_inst.setSpace(1'b1);
    repeat (len) @(posedge clk);
    xfer(3'h3, 1'b0, 32'h0, q);
    chk(q[0], det & c1[3], "flag at minimum time");
    if (det) chk(q[2], 1'b0, "idle during break");
    ucb_remote_node_inst.setSpace(1'b0);
    repeat (10) @(posedge clk);
    xfer(3'h3, 1'b0, 32'h0, q);
    chk(q[0], det, "flag after return");
    if (c1[7]) chk(q[2], 1'b1, "idle again");
  endtask
  task automatic tWake;
    wr(3'h1, 32'h0000_0098);
    sleepReq <= 1'b1;
    ucb_remote_node_inst.setSpace(1'b1);
    repeat (60) @(posedge clk);
    chk(uartIrqFlag, 1'b1, "wake flag");
    ucb_remote_node_inst.setSpace(1'b0);
    repeat (5) @(posedge clk);
    sleepReq <= 1'b0;
    xfer(3'h3, 1'b0, 32'h0, q);
    chk(q[0], 1'b0, "no break while asleep");
    xfer(3'h1, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0088, "wake enable cleared");
    wr(3'h3, 32'h0000_0002);
    @(posedge clk);
    chk(uartIrqFlag, 1'b0, "irq cleared");
  endtask
  task automatic tSend;
    wr(3'h0, 32'h0000_00AB);
    wr(3'h1, 32'h0000_0081);
    xfer(3'h1, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0080, "send break read-only");
    wr(3'h0, 32'h0000_00A0);
    wr(3'h2, 32'h0000_0002);
    wr(3'h1, 32'h0000_0081);
    ucb_remote_node_inst.maxRun = 0;
    wr(3'h5, 32'h0000_00FF);
    repeat (5) @(posedge clk);
    chk(txOe, 1'b1, "pin forced on");
    chk(txDriveEn, 1'b1, "drive enable");
    repeat (200) @(posedge clk);
    chk(ucb_remote_node_inst.maxRun, 32'd52, "break length");
    xfer(3'h1, 1'b0, 32'h0, q);
    chk(q, 32'h0000_0080, "send break cleared");
    chk(txOe, 1'b0, "port governs pin");
    portDriveEn <= 1'b1;
    @(posedge clk);
    chk(txOe, 1'b1, "port drive while idle");
    portDriveEn <= 1'b0;
    wr(3'h0, 32'h0000_0030);
    wr(3'h0, 32'h0000_0000);
    // A byte written with transmit off must survive receive enable toggles
    wr(3'h5, 32'h0000_0055);
    wr(3'h0, 32'h0000_0010);
    wr(3'h0, 32'h0000_0000);
    xfer(3'h3, 1'b0, 32'h0, q);
    chk(q[3], 1'b0, "byte kept over enables");
    chk(flushCnt, 32'd0, "enables do not flush");
    wr(3'h3, 32'h0000_0048);
    repeat (2) @(posedge clk);
    chk(flushCnt, 32'd1, "flush by status");
    xfer(3'h3, 1'b0, 32'h0, q);
    chk(q[3], 1'b1, "buffer emptied by status");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tModes();
    tTxLine();
    brk(8'h90, 8'h88, 60, 1'b1);
    brk(8'h90, 8'h88, 30, 1'b0);
    brk(8'h90, 8'h80, 60, 1'b1);
    brk(8'h9A, 8'h88, 70, 1'b0);
    brk(8'h9A, 8'h88, 110, 1'b1);
    brk(8'h10, 8'h88, 150, 1'b0);
    brk(8'h10, 8'h88, 200, 1'b1);
    brk(8'h90, 8'h08, 60, 1'b0);
    wr(3'h2, 32'h0000_0040);
    ucb_remote_node_inst.setInv(1'b1);
    brk(8'h90, 8'h88, 60, 1'b1);
    ucb_remote_node_inst.setInv(1'b0);
    wr(3'h2, 32'h0000_0080);
    @(posedge clk);
    rxOverflow <= 1'b1;
    @(posedge clk);
    rxOverflow <= 1'b0;
    brk(8'h90, 8'h88, 60, 1'b1);
    wr(3'h2, 32'h0000_0000);
    brk(8'h90, 8'h88, 60, 1'b0);
    wr(3'h3, 32'h0000_0020);
    tWake();
    tAbd(8'h50, 8'h10);
    tAbd(8'h58, 8'h58);
    tSend();
    wrapUp();
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    wrapUp();
  end
endmodule
`default_nettype wire
